//--- rtl/nco_top.sv
/*
  Numerically controlled oscillator with its AXI4-Lite register slave.
  A selected input clock, sampled on aclk, steps a 20-bit accumulator
  by a double-buffered 16-bit increment; the carry shapes the output.
  Assumes the four clock sources are much slower than aclk (each high
  and low phase spans at least three aclk cycles) and a single AXI
  master that keeps the AXI4-Lite handshake rules.
*/
`timescale 1ns/1ps
`default_nettype none
module nco_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        external_clock_pin,
  input  wire logic        system_oscillator,
  input  wire logic        internal_fast_oscillator,
  input  wire logic        logic_cell_output,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             oscillator_output,
  output logic             raw_overflow_pulse,
  output logic             overflow_interrupt_flag,
  output logic             pin_out,
  output logic             pin_oe
);

  // ****************************************************************
  // State and combinational helpers.
  // ****************************************************************
  nco_pkg::nco_state_type st_r;
  nco_pkg::nco_state_type st_nxt;
  logic [3:0]                 src_pins;
  logic                       tick;
  logic [nco_pkg::ACC_W:0]    sum;
  logic [nco_pkg::CNT_W:0]    width;
  logic                       wr_go;
  logic                       wr_hit;
  logic [31:0]                rd_word;
  logic                       rd_hit;

  // Source order follows the select code.
  assign src_pins = {logic_cell_output, internal_fast_oscillator,
                     system_oscillator, external_clock_pin};

  // Rise of the selected source once the filtered level moves up.
  // A filtered level per source avoids a false tick on reselection.
  assign tick = st_r.s2[st_r.cks] & st_r.s3[st_r.cks]
                & ~st_r.lvl[st_r.cks] & st_r.en;

  // Free-running full adder, independent of the source clock.
  assign sum = {1'b0, st_r.acc}
               + {{(nco_pkg::ACC_W - nco_pkg::INC_W + 1){1'b0}}, st_r.inc_buf};

  // Pulse width as a count of input periods.
  assign width = (nco_pkg::CNT_W + 1)'(1) << st_r.pws;

  // A write is carried out once address and data have both arrived.
  assign wr_go = st_r.aw_have & st_r.w_have & ~st_r.bvalid;

  // ****************************************************************
  // Read decode.
  // ****************************************************************
  // The increment buffer has no address of its own.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      nco_pkg::OSC_CTRL_OFS: begin
        rd_word[nco_pkg::CTRL_EN_BIT]  = st_r.en;
        rd_word[nco_pkg::CTRL_OE_BIT]  = st_r.oe;
        rd_word[nco_pkg::CTRL_OUT_BIT] = st_r.out;
        rd_word[nco_pkg::CTRL_POL_BIT] = st_r.pol;
        rd_word[nco_pkg::CTRL_PFM_BIT] = st_r.pfm;
      end
      nco_pkg::CLK_CTRL_OFS: begin
        rd_word[nco_pkg::CLK_PWS_LSB +: 3] = st_r.pws;
        rd_word[nco_pkg::CLK_CKS_LSB +: 2] = st_r.cks;
      end
      nco_pkg::ACC_LOW_OFS:   rd_word[7:0] = st_r.acc[7:0];
      nco_pkg::ACC_HIGH_OFS:  rd_word[7:0] = st_r.acc[15:8];
      nco_pkg::ACC_UPPER_OFS: rd_word[3:0] = st_r.acc[19:16];
      nco_pkg::INC_LOW_OFS:   rd_word[7:0] = st_r.inc_l;
      nco_pkg::INC_HIGH_OFS:  rd_word[7:0] = st_r.inc_h;
      nco_pkg::STATUS_OFS:    rd_word[nco_pkg::STAT_FLAG_BIT] = st_r.flag;
      default:                rd_hit = 1'b0;
    endcase
  end

  // Write address lands on a mapped register.
  always_comb begin
    unique case (st_r.awaddr)
      nco_pkg::OSC_CTRL_OFS, nco_pkg::CLK_CTRL_OFS,
      nco_pkg::ACC_LOW_OFS, nco_pkg::ACC_HIGH_OFS,
      nco_pkg::ACC_UPPER_OFS, nco_pkg::INC_LOW_OFS,
      nco_pkg::INC_HIGH_OFS, nco_pkg::STATUS_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ovf = 1'b0;

    // Three-stage sampling of the asynchronous clock sources.
    st_nxt.s1 = src_pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 4; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end

    // Accumulate and shape the output on each input tick.
    if (tick) begin
      st_nxt.acc = sum[nco_pkg::ACC_W-1:0];
      st_nxt.ovf = sum[nco_pkg::ACC_W];
      if (st_r.inc_pend) begin
        // Old increment served this addition; the new one takes the next.
        st_nxt.inc_buf  = {st_r.inc_h, st_r.inc_l};
        st_nxt.inc_pend = 1'b0;
      end
      if (!st_r.pfm) begin
        if (sum[nco_pkg::ACC_W]) begin
          st_nxt.q = ~st_r.q;
        end
        st_nxt.pf_pend = 1'b0;
      end else begin
        // Overflow is noted now and shown on the following tick.
        st_nxt.pf_pend = sum[nco_pkg::ACC_W];
        if (st_r.pf_pend) begin
          st_nxt.q   = 1'b1;
          st_nxt.cnt = width[nco_pkg::CNT_W-1:0] - nco_pkg::CNT_W'(1);
        end else if (st_r.q) begin
          if (st_r.cnt == '0) begin
            st_nxt.q = 1'b0;
          end else begin
            st_nxt.cnt = st_r.cnt - nco_pkg::CNT_W'(1);
          end
        end
      end
    end

    // Write address and data channels, taken in either order.
    if (s_axi_awvalid && !st_r.aw_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_have && !st_r.bvalid) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata  = s_axi_wdata[7:0];
      st_nxt.wstb   = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Register write; software wins over a tick in the same cycle, except that a carry on that tick still sets the flag.
    if (wr_go) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = wr_hit ? nco_pkg::RESP_OKAY : nco_pkg::RESP_SLVERR;
      if (st_r.wstb) begin
        unique case (st_r.awaddr)
          nco_pkg::OSC_CTRL_OFS: begin
            st_nxt.en  = st_r.wdata[nco_pkg::CTRL_EN_BIT];
            st_nxt.oe  = st_r.wdata[nco_pkg::CTRL_OE_BIT];
            st_nxt.pol = st_r.wdata[nco_pkg::CTRL_POL_BIT];
            st_nxt.pfm = st_r.wdata[nco_pkg::CTRL_PFM_BIT];
          end
          nco_pkg::CLK_CTRL_OFS: begin
            st_nxt.pws = st_r.wdata[nco_pkg::CLK_PWS_LSB +: 3];
            st_nxt.cks = st_r.wdata[nco_pkg::CLK_CKS_LSB +: 2];
          end
          nco_pkg::ACC_LOW_OFS:   st_nxt.acc[7:0]   = st_r.wdata;
          nco_pkg::ACC_HIGH_OFS:  st_nxt.acc[15:8]  = st_r.wdata;
          nco_pkg::ACC_UPPER_OFS: st_nxt.acc[19:16] = st_r.wdata[3:0];
          nco_pkg::INC_LOW_OFS: begin
            st_nxt.inc_l = st_r.wdata;
            if (st_r.en) begin
              st_nxt.inc_pend = 1'b1;
            end else begin
              st_nxt.inc_buf = {st_r.inc_h, st_r.wdata};
            end
          end
          nco_pkg::INC_HIGH_OFS: begin
            st_nxt.inc_h = st_r.wdata;
            if (!st_r.en) begin
              st_nxt.inc_buf = {st_r.wdata, st_r.inc_l};
            end
          end
          nco_pkg::STATUS_OFS: begin
            if (st_r.wdata[nco_pkg::STAT_FLAG_BIT]) begin
              st_nxt.flag = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    // Output level after polarity; a polarity flip while enabled counts.
    st_nxt.out = st_nxt.q ^ st_nxt.pol;
    if (st_nxt.ovf || (st_r.en && (st_nxt.pol != st_r.pol))) begin
      st_nxt.flag = 1'b1;
    end

    // Read channel: one outstanding read.
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_word;
      st_nxt.rresp  = rd_hit ? nco_pkg::RESP_OKAY : nco_pkg::RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // Every field, control and data alike, clears on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // Handshake readies are combinational; everything else is registered.
  assign s_axi_awready           = ~st_r.aw_have & ~st_r.bvalid;
  assign s_axi_wready            = ~st_r.w_have & ~st_r.bvalid;
  assign s_axi_arready           = ~st_r.rvalid;
  assign s_axi_bvalid            = st_r.bvalid;
  assign s_axi_bresp             = st_r.bresp;
  assign s_axi_rvalid            = st_r.rvalid;
  assign s_axi_rdata             = st_r.rdata;
  assign s_axi_rresp             = st_r.rresp;
  assign oscillator_output       = st_r.out;
  assign raw_overflow_pulse      = st_r.ovf;
  assign overflow_interrupt_flag = st_r.flag;
  assign pin_out                 = st_r.out;
  assign pin_oe                  = st_r.oe;

endmodule // nco_top
`default_nettype wire

//--- inc/nco_pkg.sv
/*
  Package of the numerically controlled oscillator: register offsets,
  field positions, reset values and the packed state of the block.
  Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
*/
`default_nettype none
package nco_pkg;
  // ****************************************************************
  // Register map (byte addresses, one aligned word each).
  // ****************************************************************
  localparam logic [7:0] OSC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CLK_CTRL_OFS   = 8'h04;
  localparam logic [7:0] ACC_LOW_OFS    = 8'h08;
  localparam logic [7:0] ACC_HIGH_OFS   = 8'h0C;
  localparam logic [7:0] ACC_UPPER_OFS  = 8'h10;
  localparam logic [7:0] INC_LOW_OFS    = 8'h14;
  localparam logic [7:0] INC_HIGH_OFS   = 8'h18;
  localparam logic [7:0] STATUS_OFS     = 8'h1C;
  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_OE_BIT   = 6;
  localparam int CTRL_OUT_BIT  = 5;
  localparam int CTRL_POL_BIT  = 4;
  localparam int CTRL_PFM_BIT  = 0;
  localparam int CLK_PWS_LSB   = 5;
  localparam int CLK_CKS_LSB   = 0;
  localparam int STAT_FLAG_BIT = 0;
  // ****************************************************************
  // Clock source codes and widths.
  // ****************************************************************
  localparam logic [1:0] CKS_EXT_PIN    = 2'h0;
  localparam logic [1:0] CKS_SYS_OSC    = 2'h1;
  localparam logic [1:0] CKS_FAST_OSC   = 2'h2;
  localparam logic [1:0] CKS_LOGIC_CELL = 2'h3;
  localparam int ACC_W = 20;
  localparam int INC_W = 16;
  localparam int CNT_W = 7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  // ****************************************************************
  // Whole state of the block, registered as one word.
  // ****************************************************************
  typedef struct packed {
    logic [3:0]       s1;
    logic [3:0]       s2;
    logic [3:0]       s3;
    logic [3:0]       lvl;
    logic             en;
    logic             oe;
    logic             pol;
    logic             pfm;
    logic [2:0]       pws;
    logic [1:0]       cks;
    logic [ACC_W-1:0] acc;
    logic [7:0]       inc_l;
    logic [7:0]       inc_h;
    logic [INC_W-1:0] inc_buf;
    logic             inc_pend;
    logic             q;
    logic             pf_pend;
    logic [CNT_W-1:0] cnt;
    logic             out;
    logic             ovf;
    logic             flag;
    logic             aw_have;
    logic [7:0]       awaddr;
    logic             w_have;
    logic [7:0]       wdata;
    logic             wstb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } nco_state_type;
endpackage
`default_nettype wire

//--- tb/nco_src_model.sv
/*
  Far-side model: the four selectable input clocks of the oscillator.
  Assumes a free-running aclk; every source stands low between bursts.
*/
`timescale 1ns/1ps
`default_nettype none
module nco_src_model (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [7:0] extra,
  output var  logic [3:0] src
);
  // ********
  // Bursts.
  // ********
  // Source k gives k+2+extra rises, so the selected code shows in the sum.
  for (genvar k = 0; k < 4; k++) begin : g_src
    initial begin
      src[k] = 1'b0;
      forever begin
        wait (go === 1'b1);
        repeat (k + 2 + int'(extra)) begin
          repeat (4) @(posedge aclk);
          src[k] <= 1'b1;
          repeat (4) @(posedge aclk);
          src[k] <= 1'b0;
        end
        wait (go === 1'b0);
      end
    end
  end
endmodule  // nco_src_model
`default_nettype wire

//--- tb/nco_asserts.sv
/*
  Checker of the oscillator's top-level ports.
  Assumes one aclk domain; bound into every instance of the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module nco_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic oscillator_output,
  input wire logic raw_overflow_pulse,
  input wire logic overflow_interrupt_flag,
  input wire logic pin_out,
  input wire logic pin_oe
);
  // ********
  // Bus and output properties.
  // ********
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Address and data taken together start the two-step write answer.
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_rd_resp;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_rd_one;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("read answer repeated");
  property p_raw_once;
    raw_overflow_pulse |=> !raw_overflow_pulse [*4];
  endproperty
  a_raw_once: assert property (p_raw_once) else $error("carry pulse too long");
  property p_flag_set;
    raw_overflow_pulse |-> ##[0:1] overflow_interrupt_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not raised");
  // The flag only falls when a register write completes.
  property p_flag_clr;
    $fell(overflow_interrupt_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag lost");
  property p_pin;
    pin_out == oscillator_output;
  endproperty
  a_pin: assert property (p_pin) else $error("pin differs from output");
  // Reset itself is the subject here, so it must not disable the check.
  property p_rst;
    disable iff (1'b0)
    !aresetn |=> !(oscillator_output || raw_overflow_pulse || pin_oe
                   || overflow_interrupt_flag || s_axi_bvalid || s_axi_rvalid);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule  // nco_asserts
bind nco_top nco_asserts u_chk (
  .aclk                    (aclk),
  .aresetn                 (aresetn),
  .s_axi_awvalid           (s_axi_awvalid),
  .s_axi_awready           (s_axi_awready),
  .s_axi_wvalid            (s_axi_wvalid),
  .s_axi_wready            (s_axi_wready),
  .s_axi_bvalid            (s_axi_bvalid),
  .s_axi_arvalid           (s_axi_arvalid),
  .s_axi_arready           (s_axi_arready),
  .s_axi_rvalid            (s_axi_rvalid),
  .s_axi_rready            (s_axi_rready),
  .oscillator_output       (oscillator_output),
  .raw_overflow_pulse      (raw_overflow_pulse),
  .overflow_interrupt_flag (overflow_interrupt_flag),
  .pin_out                 (pin_out),
  .pin_oe                  (pin_oe)
);
`default_nettype wire

//--- tb/tb_top.sv
/*
  Self-checking bench of the oscillator, driven over AXI4-Lite.
  Assumes the design package and top, the source model and the checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ********
  // Signals.
  // ********
  localparam logic [7:0] CTL = nco_pkg::OSC_CTRL_OFS;
  localparam logic [7:0] ST  = nco_pkg::STATUS_OFS;
  logic        aclk, aresetn, awv, wv, arv, go, awr, wrd, bv, arr, rv;
  logic        osc, raw, flg, pout, poe, pol_e, act_q;
  logic [7:0]  awa, ara, extra;
  logic [31:0] wd, rdt;
  logic [3:0]  src, ws;
  logic [1:0]  brs, rrs;
  int          error_cnt, cmp_count, cyc, raw_cnt, act_cnt, t_raw, t_act;
  // Ready signals are held high, so every answer is taken when it shows.
  nco_top uut (.aclk(aclk), .aresetn(aresetn), .external_clock_pin(src[0]),
    .system_oscillator(src[1]), .internal_fast_oscillator(src[2]),
    .logic_cell_output(src[3]), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .oscillator_output(osc), .raw_overflow_pulse(raw),
    .overflow_interrupt_flag(flg), .pin_out(pout), .pin_oe(poe));
  nco_src_model u_src (.aclk(aclk), .go(go), .extra(extra), .src(src));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Watchdog, carry count and active-level timing.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
    if (raw === 1'b1) begin
      raw_cnt <= raw_cnt + 1;
      t_raw <= cyc;
    end
    act_q <= (osc !== pol_e);
    if (osc !== pol_e) act_cnt <= act_cnt + 1;
    if (osc !== pol_e && !act_q) t_act <= cyc;
  end
  // ********
  // Tasks.
  // ********
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ready is sampled mid-cycle, where it is settled, and acted on at the edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = nco_pkg::RESP_OKAY);
    logic pa, pw;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      pa = pa && !awr;
      pw = pw && !wrd;
      @(posedge aclk);
      awv <= pa;
      wv <= pw;
    end
    do begin
      @(negedge aclk);
      pa = bv;
      r = brs;
      @(posedge aclk);
    end while (!pa);
    chk(r, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] er = nco_pkg::RESP_OKAY);
    logic p;
    logic [31:0] d;
    logic [1:0] r;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(negedge aclk);
      p = arr;
      @(posedge aclk);
    end while (!p);
    arv <= 1'b0;
    do begin
      @(negedge aclk);
      p = rv;
      d = rdt;
      r = rrs;
      @(posedge aclk);
    end while (!p);
    chk(d, {24'h0, e});
    chk(r, er);
  endtask
  task automatic acc_set(input logic [19:0] v);
    wr(nco_pkg::ACC_LOW_OFS, v[7:0]);
    wr(nco_pkg::ACC_HIGH_OFS, v[15:8]);
    wr(nco_pkg::ACC_UPPER_OFS, {4'h0, v[19:16]});
  endtask
  task automatic acc_chk(input logic [19:0] e);
    rd(nco_pkg::ACC_LOW_OFS, e[7:0]);
    rd(nco_pkg::ACC_HIGH_OFS, e[15:8]);
    rd(nco_pkg::ACC_UPPER_OFS, {4'h0, e[19:16]});
  endtask
  task automatic inc_set(input logic [15:0] v);
    wr(nco_pkg::INC_HIGH_OFS, v[15:8]);
    wr(nco_pkg::INC_LOW_OFS, v[7:0]);
  endtask
  // The wait covers the longest burst of the model plus the input filter.
  task automatic burst(input logic [7:0] n);
    extra <= n;
    go <= 1'b1;
    repeat ((int'(n) + 5) * 8 + 16) @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic conclude;
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ********
  // Scenarios.
  // ********
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
      rd(8'(i * 4), 8'h00);
    rd(8'h20, 8'h00, nco_pkg::RESP_SLVERR);
    wr(8'h20, 8'hFF, nco_pkg::RESP_SLVERR);
    // A write with its low byte lane off must leave the register alone.
    ws <= 4'h0;
    wr(nco_pkg::ACC_LOW_OFS, 8'hAA);
    ws <= 4'hF;
    rd(nco_pkg::ACC_LOW_OFS, 8'h00);
    wr(nco_pkg::ACC_UPPER_OFS, 8'hFF);
    rd(nco_pkg::ACC_UPPER_OFS, 8'h0F);
    wr(CTL, 8'h5F);
    rd(CTL, 8'h71);
    chk(osc, 1'b1);
  endtask
  // Every source code with a preset near the top, so each run carries once.
  task automatic t_sources;
    logic [19:0] e;
    int r0;
    for (int k = 0; k < 4; k++) begin
      e = 20'hF0000 + 20'(k + 2) * 20'hFFFF;
      wr(CTL, 8'h00);
      inc_set(16'hFFFF);
      acc_set(20'hF0000);
      wr(nco_pkg::CLK_CTRL_OFS, 8'(k));
      wr(CTL, {1'b1, k[0], 6'h00});
      r0 = raw_cnt;
      burst(8'h00);
      chk(raw_cnt - r0, 1);
      acc_chk(e);
      chk(osc, raw_cnt[0]);
      chk(poe, k[0]);
      rd(CTL, {1'b1, k[0], raw_cnt[0], 5'h00});
      rd(ST, 8'h01);
      wr(ST, 8'h01);
      rd(ST, 8'h00);
    end
  endtask
  // While running, the first tick still uses the old increment.
  task automatic t_dbuf;
    wr(CTL, 8'h00);
    acc_set(20'h00000);
    wr(nco_pkg::CLK_CTRL_OFS, 8'h00);
    wr(CTL, 8'h80);
    inc_set(16'h0001);
    rd(nco_pkg::INC_LOW_OFS, 8'h01);
    burst(8'h00);
    acc_chk(20'h10000);
  endtask
  // Every width code, with the polarity alternating between codes.
  task automatic t_pulse;
    int a0;
    for (int w = 0; w < 8; w++) begin
      pol_e <= w[0];
      wr(CTL, 8'h00);
      inc_set(16'h0001);
      acc_set(20'hFFFFF);
      wr(nco_pkg::CLK_CTRL_OFS, {w[2:0], 5'h01});
      wr(CTL, {3'b100, w[0], 3'h0, 1'b1});
      rd(CTL, {2'b10, w[0], w[0], 3'h0, 1'b1});
      chk(osc, w[0]);
      a0 = act_cnt;
      burst(8'(1 << w));
      chk(act_cnt - a0, (1 << w) * 8);
      chk((t_act - t_raw) inside {[5:11]}, 1'b1);
      wr(ST, 8'h01);
      wr(CTL, {3'b100, ~w[0], 3'h0, 1'b1});
      rd(ST, 8'h01);
    end
  endtask
  initial begin
    {awv, wv, arv, go, pol_e, awa, ara, extra, wd} <= '0;
    ws <= 4'hF;
    do_reset();
    t_regs();
    t_sources();
    t_dbuf();
    do_reset();
    t_pulse();
    conclude();
  end
endmodule  // tb_top
`default_nettype wire
